// File: ldio_decode.sv
// Logical device activation, base registers and host I/O cycle decode
`default_nettype none

module ldio_decode (
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  input  wire ldio_pkg::ldio_cfg_t cfg_in,
  input  wire ldio_pkg::ldio_pwr_t pwr_in,
  input  wire ldio_pkg::ldio_io_t  io_in,
  output logic [7:0]               cfg_rdata_out,
  output logic [8:0]               active_out,
  output ldio_pkg::ldio_claim_t    claim_out
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [3:0]  ldn;
  logic [3:0]  next_ldn;
  logic [8:0]  act;
  logic [8:0]  next_act;
  logic [15:0] b0      [ldio_pkg::NFUNC];
  logic [15:0] next_b0 [ldio_pkg::NFUNC];
  logic [15:0] b1      [ldio_pkg::NFUNC];
  logic [15:0] next_b1 [ldio_pkg::NFUNC];
  logic [7:0]  rdata;
  logic [7:0]  next_rdata;
  ldio_pkg::ldio_claim_t claim;
  ldio_pkg::ldio_claim_t next_claim;

  // Window results
  logic        win_valid [ldio_pkg::NWIN];
  logic        win_hit   [ldio_pkg::NWIN];
  logic [2:0]  win_off   [ldio_pkg::NWIN];

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic func_ok(input logic [3:0] f);
    func_ok = (f < 4'(ldio_pkg::NFUNC));
  endfunction

  function automatic logic [3:0] func_idx(input ldio_pkg::ldio_func_t f);
    func_idx = 4'(f);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Configuration writes; power write last so it wins a same-cycle clash
  always_comb begin
    next_ldn = ldn;
    next_act = act;
    next_b0  = b0;
    next_b1  = b1;
    if (cfg_in.wr) begin
      case (cfg_in.idx)
        ldio_pkg::IDX_LDN: begin
          next_ldn = cfg_in.data[3:0];
        end
        ldio_pkg::IDX_ACT: begin
          if (func_ok(ldn)) begin
            next_act[ldn] = cfg_in.data[ldio_pkg::ACT_BIT];
          end
        end
        ldio_pkg::IDX_B0HI: begin
          if (func_ok(ldn) && ldio_pkg::USES_B0[ldn]) begin
            next_b0[ldn][15:8] = cfg_in.data;
          end
        end
        ldio_pkg::IDX_B0LO: begin
          if (func_ok(ldn) && ldio_pkg::USES_B0[ldn]) begin
            next_b0[ldn][7:0] = cfg_in.data;
          end
        end
        ldio_pkg::IDX_B1HI: begin
          if (func_ok(ldn) && ldio_pkg::USES_B1[ldn]) begin
            next_b1[ldn][15:8] = cfg_in.data;
          end
        end
        ldio_pkg::IDX_B1LO: begin
          if (func_ok(ldn) && ldio_pkg::USES_B1[ldn]) begin
            next_b1[ldn][7:0] = cfg_in.data;
          end
        end
        default: begin
        end
      endcase
    end
    // One stored bit serves as both activate and power control
    if (pwr_in.wr && func_ok(pwr_in.func)) begin
      next_act[pwr_in.func] = pwr_in.on;
    end
  end

  // Configuration reads; absent registers return zero
  always_comb begin
    next_rdata = rdata;
    if (cfg_in.rd) begin
      next_rdata = 8'h00;
      case (cfg_in.idx)
        ldio_pkg::IDX_LDN:  next_rdata = {4'h0, ldn};
        ldio_pkg::IDX_ACT:  next_rdata = func_ok(ldn) ? {7'h00, act[ldn]} : 8'h00;
        ldio_pkg::IDX_B0HI: next_rdata = func_ok(ldn) ? b0[ldn][15:8] : 8'h00;
        ldio_pkg::IDX_B0LO: next_rdata = func_ok(ldn) ? b0[ldn][7:0] : 8'h00;
        ldio_pkg::IDX_B1HI: next_rdata = func_ok(ldn) ? b1[ldn][15:8] : 8'h00;
        ldio_pkg::IDX_B1LO: next_rdata = func_ok(ldn) ? b1[ldn][7:0] : 8'h00;
        default:            next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ldn   <= ldio_pkg::LDN_RST;
      act   <= '0;
      rdata <= 8'h00;
      for (int i = 0; i < ldio_pkg::NFUNC; i++) begin
        b0[i] <= ldio_pkg::BASE_RST;
        b1[i] <= ldio_pkg::BASE_RST;
      end
    end else begin
      ldn   <= next_ldn;
      act   <= next_act;
      rdata <= next_rdata;
      b0    <= next_b0;
      b1    <= next_b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Relocatable windows, one per base use, two (4- and 8-aligned) for the parallel base
  for (genvar w = 0; w < ldio_pkg::NWIN; w++) begin : g_win
    ldio_window #(
      .LO   (ldio_pkg::WIN[w].lo),
      .HI   (ldio_pkg::WIN[w].hi),
      .MASK (ldio_pkg::WIN[w].mask)
    ) u_win (
      .base_in   (ldio_pkg::WIN[w].sel_b1 ? b1[ldio_pkg::WIN[w].func] : b0[ldio_pkg::WIN[w].func]),
      .addr_in   (io_in.addr[11:0]),
      .valid_out (win_valid[w]),
      .hit_out   (win_hit[w]),
      .off_out   (win_off[w])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-function hit; lowest function number wins an overlap
  always_comb begin
    logic [11:0] a;
    logic [11:0] pp_d;
    logic        epp;
    logic        ext;
    logic [8:0]  fhit;
    logic [2:0]  foff [ldio_pkg::NFUNC];
    logic [8:0]  falt;
    a    = io_in.addr[11:0];
    pp_d = a - b0[func_idx(ldio_pkg::F_PARALLEL)][11:0];
    epp  = win_valid[6];
    ext  = win_valid[5] && (pp_d >= ldio_pkg::PP_EXT_FIRST) &&
           (pp_d <= ldio_pkg::PP_EXT_LAST);
    fhit = '0;
    falt = '0;
    for (int f = 0; f < ldio_pkg::NFUNC; f++) begin
      foff[f] = 3'h0;
    end
    // Floppy leaves its +6 byte to someone else
    fhit[0] = win_hit[0] && (win_off[0] != ldio_pkg::FDC_HOLE);
    foff[0] = win_off[0];
    // Disk task block first, alternate status second
    fhit[1] = win_hit[1] || win_hit[2];
    foff[1] = win_hit[1] ? win_off[1] : 3'h0;
    falt[1] = !win_hit[1];
    fhit[2] = win_hit[3] || win_hit[4];
    foff[2] = win_hit[3] ? win_off[3] : 3'h0;
    falt[2] = !win_hit[3];
    // Parallel: 8-aligned base opens +3..+7, 4-aligned stops at +2
    if (epp) begin
      fhit[3] = win_hit[6] || ext;
      foff[3] = win_off[6];
    end else begin
      fhit[3] = (win_hit[5] && (win_off[5] < ldio_pkg::PP_EPP_FIRST)) || ext;
      foff[3] = win_off[5];
    end
    fhit[4] = win_hit[7];
    foff[4] = win_off[7];
    fhit[5] = win_hit[8];
    foff[5] = win_off[8];
    // Clock keeps its fixed pair even when the movable pair is set
    if ((a == ldio_pkg::CLK_FIX_IDX) || (a == ldio_pkg::CLK_FIX_DATA)) begin
      fhit[6] = 1'b1;
      foff[6] = {2'h0, a[0]};
    end else begin
      fhit[6] = win_hit[9];
      foff[6] = win_off[9];
      falt[6] = 1'b1;
    end
    fhit[7] = (a == ldio_pkg::KBD_DATA) || (a == ldio_pkg::KBD_CMD);
    foff[7] = a[2:0];
    // Aux read byte and write byte are direction bound
    fhit[8] = (win_hit[10] && io_in.rd) || (win_hit[11] && io_in.wr);
    falt[8] = !(win_hit[10] && io_in.rd);
    fhit = fhit & act;
    next_claim = '0;
    for (int f = ldio_pkg::NFUNC - 1; f >= 0; f--) begin
      if (fhit[f] && (io_in.rd || io_in.wr)) begin
        next_claim.hit  = 1'b1;
        next_claim.func = 4'(f);
        next_claim.off  = foff[f];
        next_claim.alt  = falt[f];
      end
    end
    next_claim.rd = next_claim.hit && io_in.rd;
    next_claim.wr = next_claim.hit && io_in.wr;
    if (next_claim.hit && (next_claim.func == func_idx(ldio_pkg::F_PARALLEL)) && ext &&
        !(epp ? win_hit[6] : win_hit[5])) begin
      next_claim.ext     = 1'b1;
      next_claim.off     = 3'h0;
      next_claim.ext_off = pp_d[1:0];
    end
    next_claim.data16 = next_claim.hit && !next_claim.alt &&
                        ((next_claim.func == func_idx(ldio_pkg::F_DISK1)) ||
                         (next_claim.func == func_idx(ldio_pkg::F_DISK2))) &&
                        (next_claim.off == ldio_pkg::DISK_DATA);
    next_claim.epp = next_claim.hit && !next_claim.ext && epp &&
                     (next_claim.func == func_idx(ldio_pkg::F_PARALLEL)) &&
                     (next_claim.off >= ldio_pkg::PP_EPP_FIRST);
  end

  // Claim is registered: one cycle after the strobe
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      claim <= '0;
    end else begin
      claim <= next_claim;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign cfg_rdata_out = rdata;
  assign active_out    = act;
  assign claim_out     = claim;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [8:0] act_prev;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      act_prev <= '0;
    end else begin
      act_prev <= act;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_pwr_write;
    pwr_in.wr && func_ok(pwr_in.func) && !cfg_in.wr;
  endsequence

  a_inactive_quiet: assert property (claim.hit |-> act_prev[claim.func])
    else $error("Claim by an inactive function");
  a_power_link: assert property (s_pwr_write |=> act[$past(pwr_in.func)] == $past(pwr_in.on))
    else $error("Power write did not move the activate bit");
  a_floppy_hole: assert property (claim.hit && claim.func == 4'h0 |-> claim.off != ldio_pkg::FDC_HOLE)
    else $error("Floppy claimed its unused byte");
  a_floppy_range: assert property (claim.hit && claim.func == 4'h0 |->
      $past(b0[0]) >= 16'h0100 && $past(b0[0]) <= 16'h0ff8 && $past(b0[0][2:0]) == 3'h0)
    else $error("Floppy claimed with an illegal base");
  a_keyboard_fixed: assert property (claim.hit && claim.func == 4'h7 |->
      $past(io_in.addr[11:0]) == ldio_pkg::KBD_DATA || $past(io_in.addr[11:0]) == ldio_pkg::KBD_CMD)
    else $error("Keyboard claimed off its fixed bytes");
  a_clock_fixed: assert property (io_in.rd && act[6] && io_in.addr[11:0] == ldio_pkg::CLK_FIX_DATA |=>
      claim.hit && claim.rd && (claim.func == 4'h6 || claim.func == 4'h3))
    else $error("Clock data byte not claimed");
  a_aux_direction: assert property (claim.hit && claim.func == 4'h8 |-> claim.alt == claim.wr)
    else $error("Aux byte claimed in the wrong direction");
  a_act_readback: assert property (cfg_in.rd && cfg_in.idx == ldio_pkg::IDX_ACT && func_ok(ldn) |=>
      cfg_rdata_out == {7'h00, $past(act[ldn])})
    else $error("Activate readback wrong");
  a_disk_wide: assert property (claim.data16 |-> claim.off == 3'h0 && !claim.alt)
    else $error("Wide data flagged away from the data register");

endmodule

`default_nettype wire

// File: ldio_pkg.sv
// Shared constants and carrier types for the logical device I/O decoder
`default_nettype none

package ldio_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int NFUNC = 9;
  localparam int NWIN  = 12;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration indices
  localparam logic [7:0] IDX_LDN  = 8'h07;
  localparam logic [7:0] IDX_ACT  = 8'h30;
  localparam logic [7:0] IDX_B0HI = 8'h60;
  localparam logic [7:0] IDX_B0LO = 8'h61;
  localparam logic [7:0] IDX_B1HI = 8'h62;
  localparam logic [7:0] IDX_B1LO = 8'h63;
  localparam int         ACT_BIT  = 0;

  // Reset values
  localparam logic [15:0] BASE_RST = 16'h0000;
  localparam logic [3:0]  LDN_RST  = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Logical functions, in device number order
  typedef enum logic [3:0] {
    F_FLOPPY, F_DISK1, F_DISK2, F_PARALLEL, F_SERIAL1,
    F_SERIAL2, F_CLOCK, F_KEYBOARD, F_AUX
  } ldio_func_t;

  // Bit per function: which base pairs exist
  localparam logic [8:0] USES_B0 = 9'h13f;
  localparam logic [8:0] USES_B1 = 9'h146;

  ////////////////////////////////////////////////////////////////////////////
  // Fixed addresses and offsets
  localparam logic [11:0] CLK_FIX_IDX  = 12'h070;
  localparam logic [11:0] CLK_FIX_DATA = 12'h071;
  localparam logic [11:0] KBD_DATA     = 12'h060;
  localparam logic [11:0] KBD_CMD      = 12'h064;
  localparam logic [11:0] PP_EXT_FIRST = 12'h400;
  localparam logic [11:0] PP_EXT_LAST  = 12'h402;
  localparam logic [2:0]  FDC_HOLE     = 3'h6;
  localparam logic [2:0]  PP_EPP_FIRST = 3'h3;
  localparam logic [2:0]  DISK_DATA    = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Decode windows: owner, base pair, legal base range, alignment mask
  typedef struct packed {
    logic [3:0]  func;
    logic        sel_b1;
    logic [11:0] lo;
    logic [11:0] hi;
    logic [11:0] mask;
  } ldio_win_t;

  localparam ldio_win_t WIN [NWIN] = '{
    '{4'h0, 1'b0, 12'h100, 12'hff8, 12'h007},  // Floppy
    '{4'h1, 1'b0, 12'h100, 12'hff8, 12'h007},  // Disk 1 task
    '{4'h1, 1'b1, 12'h100, 12'hfff, 12'h000},  // Disk 1 alt status
    '{4'h2, 1'b0, 12'h100, 12'hff8, 12'h007},  // Disk 2 task
    '{4'h2, 1'b1, 12'h100, 12'hfff, 12'h000},  // Disk 2 alt status
    '{4'h3, 1'b0, 12'h100, 12'hffc, 12'h003},  // Parallel, 4 aligned
    '{4'h3, 1'b0, 12'h100, 12'hff8, 12'h007},  // Parallel, 8 aligned
    '{4'h4, 1'b0, 12'h100, 12'hff8, 12'h007},  // Serial 1
    '{4'h5, 1'b0, 12'h100, 12'hff8, 12'h007},  // Serial 2
    '{4'h6, 1'b1, 12'h100, 12'hffe, 12'h001},  // Clock, movable pair
    '{4'h8, 1'b0, 12'h000, 12'hfff, 12'h000},  // Aux read byte
    '{4'h8, 1'b1, 12'h000, 12'hfff, 12'h000}   // Aux write byte
  };

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] idx;
    logic [7:0] data;
  } ldio_cfg_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
  } ldio_io_t;

  typedef struct packed {
    logic       wr;
    logic [3:0] func;
    logic       on;
  } ldio_pwr_t;

  typedef struct packed {
    logic       hit;
    logic       rd;
    logic       wr;
    logic [3:0] func;
    logic [2:0] off;
    logic       alt;
    logic       ext;
    logic [1:0] ext_off;
    logic       data16;
    logic       epp;
  } ldio_claim_t;

endpackage

`default_nettype wire

// File: ldio_window.sv
// One base address window: legality check and address match
`default_nettype none

module ldio_window #(
  parameter logic [11:0] LO   = 12'h100,
  parameter logic [11:0] HI   = 12'hff8,
  parameter logic [11:0] MASK = 12'h007
) (
  input  wire logic [15:0] base_in,
  input  wire logic [11:0] addr_in,
  output logic             valid_out,
  output logic             hit_out,
  output logic [2:0]       off_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Base must sit in range and on its boundary, else the window is dead
  always_comb begin
    valid_out = (base_in[15:12] == 4'h0) &&
                (base_in[11:0] >= LO) && (base_in[11:0] <= HI) &&
                ((base_in[11:0] & MASK) == 12'h000);
  end

  // Only A11..A0 take part in the compare
  always_comb begin
    hit_out = valid_out &&
              ((addr_in & ~MASK) == base_in[11:0]);
    off_out = addr_in[2:0] & MASK[2:0];
  end

endmodule

`default_nettype wire

// File: ldio_host.sv
// Host bus model: drives configuration, power and I/O cycles into the decoder
`default_nettype none

module ldio_host (
  input  wire logic                  clk_in,
  input  wire logic [7:0]            cfg_rdata_in,
  input  wire ldio_pkg::ldio_claim_t claim_in,
  output var  ldio_pkg::ldio_cfg_t   cfg_out,
  output var  ldio_pkg::ldio_pwr_t   pwr_out,
  output var  ldio_pkg::ldio_io_t    io_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Bus idle from time zero so no strobe is unknown
  initial begin
    cfg_out = '0;
    pwr_out = '0;
    io_out  = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration write, one-cycle strobe; data is scrambled once released
  task automatic cfg_write(input logic [7:0] idx, input logic [7:0] data);
    @(posedge clk_in);
    cfg_out <= '{1'b1, 1'b0, idx, data};
    @(posedge clk_in);
    cfg_out <= '{1'b0, 1'b0, idx, ~data};
  endtask

  // Configuration read; data is registered and taken a cycle after the strobe
  task automatic cfg_read(input logic [7:0] idx, output logic [7:0] data);
    @(posedge clk_in);
    cfg_out <= '{1'b0, 1'b1, idx, 8'h00};
    @(posedge clk_in);
    cfg_out.rd <= 1'b0;
    #1;
    data = cfg_rdata_in;
  endtask

  // Power-control write, one-cycle strobe
  task automatic pwr_write(input logic [3:0] func, input logic on);
    @(posedge clk_in);
    pwr_out <= '{1'b1, func, on};
    @(posedge clk_in);
    pwr_out <= '{1'b0, func, ~on};
  endtask

  // One strobed I/O cycle; the claim is looked at in the cycle after it
  task automatic io_cycle(input logic rd, input logic wr, input logic [15:0] addr,
                          output ldio_pkg::ldio_claim_t claim);
    @(posedge clk_in);
    io_out <= '{rd, wr, addr};
    @(posedge clk_in);
    io_out <= '{1'b0, 1'b0, ~addr};  // Released address does not keep its value
    #1;
    claim = claim_in;
  endtask

endmodule

`default_nettype wire

// File: tb_ldio_decode.sv
// Self-checking testbench for the logical device I/O decoder
`default_nettype none

module tb_ldio_decode;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  clk_in;
  logic                  rst_in;
  ldio_pkg::ldio_cfg_t   cfg;
  ldio_pkg::ldio_pwr_t   pwr;
  ldio_pkg::ldio_io_t    io;
  logic [7:0]            rdata;
  logic [8:0]            active;
  ldio_pkg::ldio_claim_t claim;
  ldio_pkg::ldio_claim_t cl;
  logic [7:0]            rd8;
  int                    fails;
  int                    n_compared;

  ldio_host i_ldio_host (
    .clk_in       (clk_in),
    .cfg_rdata_in (rdata),
    .claim_in     (claim),
    .cfg_out      (cfg),
    .pwr_out      (pwr),
    .io_out       (io)
  );

  ldio_decode i_ldio_decode (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .cfg_in        (cfg),
    .pwr_in        (pwr),
    .io_in         (io),
    .cfg_rdata_out (rdata),
    .active_out    (active),
    .claim_out     (claim)
  );

  // 40 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and comparisons
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask

  // Masked so fields the decoder zeroes on a miss are not judged
  task automatic chk_claim(input ldio_pkg::ldio_claim_t got, input ldio_pkg::ldio_claim_t exp,
                           input ldio_pkg::ldio_claim_t m);
    n_compared++;
    if ((got & m) !== (exp & m)) begin
      fails++;
      $display("unexpected at %0t: claim %h, wanted %h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Helpers; flags are {alt, ext, data16, epp}
  task automatic io_chk(input logic rd, input logic wr, input logic [15:0] a, input logic hit,
                        input logic [3:0] f, input logic [2:0] o, input logic [3:0] fl);
    ldio_pkg::ldio_claim_t e;
    ldio_pkg::ldio_claim_t m;
    i_ldio_host.io_cycle(rd, wr, a, cl);
    e = '{hit, rd, wr, f, o, fl[3], fl[2], o[1:0], fl[1], fl[0]};
    m = '1;
    if (fl[2]) m.off = 3'h0;
    else m.ext_off = 2'h0;
    if (!hit) m = '{1'b1, 1'b0, 1'b0, 4'h0, 3'h0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0};
    chk_claim(cl, e, m);
  endtask

  task automatic set_fn(input logic [3:0] f);
    i_ldio_host.cfg_write(ldio_pkg::IDX_LDN, {4'h0, f});
  endtask

  // Writes a base pair and reads both bytes back
  task automatic set_base(input logic sel, input logic [15:0] b);
    logic [7:0] hi;
    hi = sel ? ldio_pkg::IDX_B1HI : ldio_pkg::IDX_B0HI;
    i_ldio_host.cfg_write(hi, b[15:8]);
    i_ldio_host.cfg_write(hi + 8'h01, b[7:0]);
    i_ldio_host.cfg_read(hi, rd8);
    chk_vec({8'h00, rd8}, {8'h00, b[15:8]});
    i_ldio_host.cfg_read(hi + 8'h01, rd8);
    chk_vec({8'h00, rd8}, {8'h00, b[7:0]});
  endtask

  // Sets the activate bit and checks the function's on bit a cycle later
  task automatic activate(input logic [3:0] f, input logic on);
    i_ldio_host.cfg_write(ldio_pkg::IDX_ACT, {7'h00, on});
    @(posedge clk_in);
    #1;
    chk_vec({15'h0000, active[f]}, {15'h0000, on});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    chk_vec({7'h00, active}, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      i_ldio_host.cfg_read(i == 4 ? ldio_pkg::IDX_ACT : 8'h60 + 8'(i), rd8);
      chk_vec({8'h00, rd8}, 16'h0000);
    end
    io_chk(1'b1, 1'b0, 16'h0070, 1'b0, 4'h0, 3'h0, 4'h0);
  endtask

  task automatic t_serial();
    set_fn(4'h4);
    set_base(1'b0, 16'h03f8);
    activate(4'h4, 1'b1);
    i_ldio_host.cfg_write(ldio_pkg::IDX_ACT, 8'hff);
    i_ldio_host.cfg_read(ldio_pkg::IDX_ACT, rd8);
    chk_vec({8'h00, rd8}, 16'h0001);
    i_ldio_host.pwr_write(4'h4, 1'b0);
    i_ldio_host.cfg_read(ldio_pkg::IDX_ACT, rd8);
    chk_vec({8'h00, rd8}, 16'h0000);
    io_chk(1'b1, 1'b0, 16'h03f8, 1'b0, 4'h4, 3'h0, 4'h0);
    i_ldio_host.pwr_write(4'h4, 1'b1);
    i_ldio_host.cfg_read(ldio_pkg::IDX_ACT, rd8);
    chk_vec({8'h00, rd8}, 16'h0001);
    // A power write to a function number that does not exist changes nothing
    i_ldio_host.pwr_write(4'h9, 1'b1);
    @(posedge clk_in);
    #1;
    chk_vec({7'h00, active}, 16'h0010);
    for (int o = 0; o < 8; o++) begin
      io_chk(o[0], ~o[0], 16'h03f8 + 16'(o), 1'b1, 4'h4, 3'(o), 4'h0);
    end
    io_chk(1'b1, 1'b0, 16'hf3f9, 1'b1, 4'h4, 3'h1, 4'h0);
  endtask

  task automatic t_floppy();
    set_fn(4'h0);
    set_base(1'b0, 16'h03f0);
    activate(4'h0, 1'b1);
    for (int o = 0; o < 8; o++) begin
      io_chk(1'b1, 1'b0, 16'h03f0 + 16'(o), o != 6, 4'h0, 3'(o), 4'h0);
    end
    set_base(1'b0, 16'h03f4);
    io_chk(1'b1, 1'b0, 16'h03f4, 1'b0, 4'h0, 3'h0, 4'h0);
    set_base(1'b0, 16'h00f8);
    io_chk(1'b0, 1'b1, 16'h00f8, 1'b0, 4'h0, 3'h0, 4'h0);
  endtask

  task automatic t_disk(input logic [3:0] f, input logic [15:0] b, input logic [15:0] alt);
    set_fn(f);
    set_base(1'b0, b);
    set_base(1'b1, alt);
    activate(f, 1'b1);
    io_chk(1'b0, 1'b1, b, 1'b1, f, 3'h0, 4'b0010);
    io_chk(1'b1, 1'b0, b + 16'h0007, 1'b1, f, 3'h7, 4'b0000);
    io_chk(1'b1, 1'b0, b + 16'h0008, 1'b0, f, 3'h0, 4'b0000);
    io_chk(1'b1, 1'b0, alt, 1'b1, f, 3'h0, 4'b1000);
  endtask

  task automatic t_parallel();
    set_fn(4'h3);
    set_base(1'b0, 16'h0378);
    activate(4'h3, 1'b1);
    io_chk(1'b1, 1'b0, 16'h0378, 1'b1, 4'h3, 3'h0, 4'b0000);
    io_chk(1'b0, 1'b1, 16'h037b, 1'b1, 4'h3, 3'h3, 4'b0001);
    io_chk(1'b1, 1'b0, 16'h037f, 1'b1, 4'h3, 3'h7, 4'b0001);
    for (int e = 0; e < 4; e++) begin
      io_chk(1'b1, 1'b0, 16'h0778 + 16'(e), e < 3, 4'h3, 3'(e), 4'b0100);
    end
    set_base(1'b0, 16'h037c);
    io_chk(1'b1, 1'b0, 16'h037e, 1'b1, 4'h3, 3'h2, 4'b0000);
    io_chk(1'b1, 1'b0, 16'h037f, 1'b0, 4'h3, 3'h3, 4'b0000);
    io_chk(1'b0, 1'b1, 16'h077d, 1'b1, 4'h3, 3'h1, 4'b0100);
  endtask

  task automatic t_clock();
    set_fn(4'h6);
    io_chk(1'b1, 1'b0, 16'h0071, 1'b0, 4'h6, 3'h1, 4'h0);
    set_base(1'b1, 16'h0ffe);
    activate(4'h6, 1'b1);
    io_chk(1'b0, 1'b1, 16'h0070, 1'b1, 4'h6, 3'h0, 4'h0);
    io_chk(1'b1, 1'b0, 16'h0071, 1'b1, 4'h6, 3'h1, 4'h0);
    io_chk(1'b1, 1'b0, 16'h0ffe, 1'b1, 4'h6, 3'h0, 4'b1000);
    io_chk(1'b0, 1'b1, 16'h0fff, 1'b1, 4'h6, 3'h1, 4'b1000);
    set_base(1'b1, 16'h0301);
    io_chk(1'b1, 1'b0, 16'h0301, 1'b0, 4'h6, 3'h0, 4'h0);
  endtask

  task automatic t_keyboard();
    set_fn(4'h7);
    i_ldio_host.cfg_write(ldio_pkg::IDX_B0HI, 8'h12);
    i_ldio_host.cfg_read(ldio_pkg::IDX_B0HI, rd8);
    chk_vec({8'h00, rd8}, 16'h0000);
    activate(4'h7, 1'b1);
    io_chk(1'b1, 1'b0, 16'h0060, 1'b1, 4'h7, 3'h0, 4'h0);
    io_chk(1'b0, 1'b1, 16'h0064, 1'b1, 4'h7, 3'h4, 4'h0);
    io_chk(1'b1, 1'b0, 16'h0062, 1'b0, 4'h7, 3'h2, 4'h0);
  endtask

  task automatic t_aux();
    set_fn(4'h8);
    set_base(1'b0, 16'h0200);
    set_base(1'b1, 16'h0205);
    activate(4'h8, 1'b1);
    io_chk(1'b1, 1'b0, 16'h0200, 1'b1, 4'h8, 3'h0, 4'b0000);
    io_chk(1'b0, 1'b1, 16'h0200, 1'b0, 4'h8, 3'h0, 4'b0000);
    io_chk(1'b0, 1'b1, 16'h0205, 1'b1, 4'h8, 3'h0, 4'b1000);
    io_chk(1'b1, 1'b0, 16'h0205, 1'b0, 4'h8, 3'h0, 4'b1000);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset held six cycles, then each scenario in turn
  initial begin
    fails = 0;
    n_compared = 0;
    rst_in = 1'b1;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_serial();
    t_floppy();
    t_disk(4'h1, 16'h01f0, 16'h03f6);
    t_disk(4'h2, 16'h0170, 16'h0376);
    t_parallel();
    t_clock();
    t_keyboard();
    t_aux();
    stop_test();
  end

  // Bound on the whole run in case a task hangs
  initial begin
    repeat (20000) @(posedge clk_in);
    fails++;
    stop_test();
  end

endmodule

`default_nettype wire
